// ### logic/scs_pkg.sv
// constants for the sar conversion sequencer
// assumes a 100 MHz hclk and an ahb-lite register bus
package scs_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned RES_BITS         = 16;
  localparam int unsigned FULL_SCALE_STEPS = 65536;
  // mode select codes
  localparam logic [1:0]  MODE_NORMAL      = 2'h0;
  localparam logic [1:0]  MODE_FAST        = 2'h1;
  localparam logic [1:0]  MODE_LOWPWR      = 2'h2;
  // rates in ksps, gap limit in us
  localparam int unsigned FAST_KSPS        = 570;
  localparam int unsigned NORMAL_KSPS      = 500;
  localparam int unsigned FAST_GAP_US      = 1000;
  localparam int unsigned FAST_PERIOD_CYC  = (CLK_MHZ * 1000 + FAST_KSPS - 1) / FAST_KSPS;
  localparam int unsigned NORM_PERIOD_CYC  = (CLK_MHZ * 1000 + NORMAL_KSPS - 1) / NORMAL_KSPS;
  localparam int unsigned FAST_GAP_CYC     = FAST_GAP_US * CLK_MHZ;
  // cycles per bit trial, and wake cycles before the first trial after power-up
  localparam int unsigned TRIAL_CYC_FAST   = 5;
  localparam int unsigned TRIAL_CYC_NORM   = 6;
  localparam int unsigned WAKE_CYC         = 4;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_STATUS       = 8'h04;
  localparam logic [7:0]  OFS_RESULT       = 8'h08;
  localparam logic [7:0]  OFS_SAMPLE       = 8'h0C;
  // ctrl fields
  localparam int unsigned CTRL_FAST_BIT    = 0;
  localparam int unsigned CTRL_LOWPWR_BIT  = 1;
  localparam int unsigned CTRL_CODING_BIT  = 2;
  localparam int unsigned CTRL_PD_BIT      = 3;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0004;
  // status fields
  localparam int unsigned ST_BUSY_BIT      = 0;
  localparam int unsigned ST_STALE_BIT     = 1;
  localparam int unsigned ST_PWRSAVE_BIT   = 2;
  typedef enum logic [3:0] {
    SCS_ACQ   = 4'h1,
    SCS_WAKE  = 4'h2,
    SCS_TRIAL = 4'h4,
    SCS_DONE  = 4'h8
  } scs_state_e;
endpackage

// ### logic/scs_sequencer.sv
// successive approximation control and output coding, ahb-lite registers
// assumes convert_start_n comes from a pin; analog sample/compare is a digital word input
//
// The AHB-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RULE1: falling convert_start_n leaves acquisition, holds the sample, starts conversion.
// RULE2: bit trials from half scale down to one step, msb first.
// RULE3: latch final code first, then drop busy.
// RULE4: each result is ready at end of its own conversion, no latency.
// RULE5: three modes: fastest, normal, low power.
// RULE6: fastest mode up to 570 ksps, accurate only with gaps under 1 ms.
// RULE7: host discards first fastest-mode result after gap over 1 ms.
// RULE8: normal mode up to 500 ksps, any gap length allowed.
// RULE9: low power mode powers down between conversions.
// RULE10: coding select picks straight binary or twos complement, 16 bits.
// RULE11: twos complement is straight binary with msb inverted.
// RULE12: overrange saturates to the maximum code.
// RULE13: underrange saturates to the minimum code.
// RULE14: low power when low-power select high and fastest select low.
// RULE15: starts and power-down ignored while a conversion runs.
// RULE16: coding select high is straight binary, sampled at latch time.
module scs_sequencer #(
  parameter int unsigned WIDTH = scs_pkg::RES_BITS
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire logic                       convert_start_n,
  input  wire logic [WIDTH-1:0]           analog_level,
  input  wire logic                       analog_over,
  input  wire logic                       analog_under,
  output logic                            busy,
  output logic                            sample_hold,
  output logic                            analog_power_on,
  output logic      [WIDTH-1:0]           trial_code,
  output logic      [WIDTH-1:0]           result_code
);
  // elaboration check: coding and saturation logic assume a 16-bit word
  if (WIDTH != scs_pkg::RES_BITS) begin : g_width_check
    $error("scs_sequencer: WIDTH must be 16");
  end

  // pin synchroniser; first stage read only by the second
  logic       cs_meta_reg;
  logic       cs_sync_reg;
  logic       cs_prev_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= convert_start_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end
  logic start_fall;
  assign start_fall = cs_prev_reg & ~cs_sync_reg;

  // bus slave, zero wait state
  logic [31:0] ctrl_reg, ctrl_next;
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        accept;
  assign accept = hsel & hready & htrans[1];

  scs_pkg::scs_state_e st_reg, st_next;
  logic [WIDTH-1:0] sar_reg, sar_next;
  logic [WIDTH-1:0] bit_reg, bit_next;
  logic [WIDTH-1:0] res_reg, res_next;
  logic [3:0]       cyc_reg, cyc_next;
  logic [1:0]       mode_reg, mode_next;
  logic             over_reg, over_next;
  logic             under_reg, under_next;
  logic [31:0]      gap_reg, gap_next;
  logic             stale_reg, stale_next;
  logic             held_reg, held_next;
  logic             pwr_reg, pwr_next;
  logic [31:0]      count_reg, count_next;

  logic [1:0] mode_sel;
  logic       pd_req;
  logic [3:0] trial_len;
  logic [WIDTH-1:0] straight;

  always_comb begin
    // RULE5 RULE14 mode decode
    if (ctrl_reg[scs_pkg::CTRL_FAST_BIT])
      mode_sel = scs_pkg::MODE_FAST;
    else if (ctrl_reg[scs_pkg::CTRL_LOWPWR_BIT])
      mode_sel = scs_pkg::MODE_LOWPWR;
    else
      mode_sel = scs_pkg::MODE_NORMAL;
    pd_req = ctrl_reg[scs_pkg::CTRL_PD_BIT];
    // RULE6 RULE8 trial pacing sets rate
    trial_len = (mode_reg == scs_pkg::MODE_FAST) ? 4'(scs_pkg::TRIAL_CYC_FAST)
                                                  : 4'(scs_pkg::TRIAL_CYC_NORM);
    // RULE12 RULE13 saturate, no wrap
    if (over_reg)
      straight = '1;
    else if (under_reg)
      straight = '0;
    else
      straight = sar_reg;
  end

  always_comb begin
    st_next    = st_reg;
    sar_next   = sar_reg;
    bit_next   = bit_reg;
    res_next   = res_reg;
    cyc_next   = cyc_reg;
    mode_next  = mode_reg;
    over_next  = over_reg;
    under_next = under_reg;
    held_next  = held_reg;
    stale_next = stale_reg;
    count_next = count_reg;
    pwr_next   = pwr_reg;
    gap_next   = (gap_reg < scs_pkg::FAST_GAP_CYC) ? gap_reg + 32'h0000_0001 : gap_reg;
    case (st_reg)
      scs_pkg::SCS_ACQ: begin
        // RULE9 low power sleeps between conversions
        pwr_next = ~pd_req & (mode_sel != scs_pkg::MODE_LOWPWR);
        // RULE1 start on falling edge
        if (start_fall && !pd_req) begin
          held_next = 1'b1;
          mode_next = mode_sel;
          // RULE7 flag result after long gap in fast mode
          stale_next = (mode_sel == scs_pkg::MODE_FAST) && (gap_reg >= scs_pkg::FAST_GAP_CYC);
          gap_next   = '0;
          over_next  = analog_over;
          under_next = analog_under;
          cyc_next   = '0;
          st_next    = pwr_reg ? scs_pkg::SCS_TRIAL : scs_pkg::SCS_WAKE;
          pwr_next   = 1'b1;
          sar_next   = {1'b1, {(WIDTH-1){1'b0}}};
          bit_next   = {1'b1, {(WIDTH-1){1'b0}}};
        end
      end
      scs_pkg::SCS_WAKE: begin
        cyc_next = cyc_reg + 4'h1;
        if (cyc_reg == 4'(scs_pkg::WAKE_CYC - 1)) begin
          cyc_next = '0;
          st_next  = scs_pkg::SCS_TRIAL;
        end
      end
      scs_pkg::SCS_TRIAL: begin
        // RULE15 starts and power-down ignored here
        cyc_next = cyc_reg + 4'h1;
        if (cyc_reg == trial_len - 4'h1) begin
          cyc_next = '0;
          // RULE2 keep or drop trial bit, msb first
          if (trial_code > analog_level)
            sar_next = (sar_reg & ~bit_reg) | (bit_reg >> 1);
          else
            sar_next = sar_reg | (bit_reg >> 1);
          bit_next = bit_reg >> 1;
          if (bit_reg[0]) begin
            sar_next = (trial_code > analog_level) ? (sar_reg & ~bit_reg) : sar_reg;
            st_next  = scs_pkg::SCS_DONE;
          end
        end
      end
      scs_pkg::SCS_DONE: begin
        // RULE3 RULE4 latch code, busy drops on the same edge
        // RULE10 RULE11 RULE16 coding applied at latch
        res_next   = ctrl_reg[scs_pkg::CTRL_CODING_BIT] ? straight
                                                        : {~straight[WIDTH-1], straight[WIDTH-2:0]};
        held_next  = 1'b0;
        count_next = count_reg + 32'h0000_0001;
        st_next    = scs_pkg::SCS_ACQ;
      end
      default: st_next = scs_pkg::SCS_ACQ;
    endcase
  end

  // bus next state
  always_comb begin
    wr_pend_next = accept & hwrite;
    addr_next    = accept ? haddr[7:0] : addr_reg;
    ctrl_next    = ctrl_reg;
    if (wr_pend_reg && addr_reg == scs_pkg::OFS_CTRL)
      ctrl_next = {28'h0, hwdata[3:0]};
    rdata_next = 32'h0000_0000;
    if (accept && !hwrite) begin
      case (haddr[7:0])
        scs_pkg::OFS_CTRL:   rdata_next = ctrl_next;
        scs_pkg::OFS_STATUS: rdata_next = {29'h0, ~pwr_reg, stale_reg, held_reg};
        scs_pkg::OFS_RESULT: rdata_next = {16'h0, res_reg};
        scs_pkg::OFS_SAMPLE: rdata_next = count_reg;
        default:             rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg      <= scs_pkg::SCS_ACQ;
      sar_reg     <= '0;
      bit_reg     <= '0;
      res_reg     <= '0;
      cyc_reg     <= '0;
      mode_reg    <= scs_pkg::MODE_NORMAL;
      over_reg    <= 1'b0;
      under_reg   <= 1'b0;
      gap_reg     <= 32'(scs_pkg::FAST_GAP_CYC);
      stale_reg   <= 1'b0;
      held_reg    <= 1'b0;
      pwr_reg     <= 1'b1;
      count_reg   <= '0;
      ctrl_reg    <= scs_pkg::CTRL_RESET;
      wr_pend_reg <= 1'b0;
      addr_reg    <= '0;
      rdata_reg   <= '0;
    end else begin
      st_reg      <= st_next;
      sar_reg     <= sar_next;
      bit_reg     <= bit_next;
      res_reg     <= res_next;
      cyc_reg     <= cyc_next;
      mode_reg    <= mode_next;
      over_reg    <= over_next;
      under_reg   <= under_next;
      gap_reg     <= gap_next;
      stale_reg   <= stale_next;
      held_reg    <= held_next;
      pwr_reg     <= pwr_next;
      count_reg   <= count_next;
      ctrl_reg    <= ctrl_next;
      wr_pend_reg <= wr_pend_next;
      addr_reg    <= addr_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign hrdata          = rdata_reg;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign busy            = held_reg;
  assign sample_hold     = held_reg;
  assign analog_power_on = pwr_reg;
  assign trial_code      = sar_reg;
  assign result_code     = res_reg;

  // assertions
  property p_start_begins;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg == scs_pkg::SCS_ACQ && start_fall && !pd_req) |=> busy;
  endproperty
  a_start_begins: assert property (p_start_begins) else $error("start edge did not raise busy"); // RULE1

  property p_msb_first;
    @(posedge hclk) disable iff (!hresetn)
      $rose(busy) |-> trial_code == {1'b1, {(WIDTH-1){1'b0}}};
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("trial did not start at midscale"); // RULE2

  property p_latch_then_busy;
    @(posedge hclk) disable iff (!hresetn)
      $fell(busy) |-> $past(st_reg) == scs_pkg::SCS_DONE;
  endproperty
  a_latch_then_busy: assert property (p_latch_then_busy) else $error("busy fell outside latch"); // RULE3

  property p_no_latency;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg == scs_pkg::SCS_DONE && ctrl_reg[scs_pkg::CTRL_CODING_BIT]) |=> result_code == $past(straight);
  endproperty
  a_no_latency: assert property (p_no_latency) else $error("result not from own conversion"); // RULE4

  property p_lowpwr_sleep;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg == scs_pkg::SCS_ACQ && mode_sel == scs_pkg::MODE_LOWPWR && !start_fall) |=> !analog_power_on;
  endproperty
  a_lowpwr_sleep: assert property (p_lowpwr_sleep) else $error("low power mode stayed powered"); // RULE9

  property p_twos;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg == scs_pkg::SCS_DONE && !ctrl_reg[scs_pkg::CTRL_CODING_BIT])
        |=> result_code == {~$past(straight[WIDTH-1]), $past(straight[WIDTH-2:0])};
  endproperty
  a_twos: assert property (p_twos) else $error("twos complement coding wrong"); // RULE11

  property p_over;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg == scs_pkg::SCS_DONE && over_reg && ctrl_reg[scs_pkg::CTRL_CODING_BIT]) |=> &result_code;
  endproperty
  a_over: assert property (p_over) else $error("overrange did not saturate"); // RULE12

  property p_under;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg == scs_pkg::SCS_DONE && under_reg && !over_reg && ctrl_reg[scs_pkg::CTRL_CODING_BIT])
        |=> result_code == '0;
  endproperty
  a_under: assert property (p_under) else $error("underrange did not saturate"); // RULE13

  property p_no_restart;
    @(posedge hclk) disable iff (!hresetn)
      (st_reg == scs_pkg::SCS_TRIAL && cyc_reg != trial_len - 4'h1) |=> $stable(trial_code) && busy;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion disturbed mid trial"); // RULE15

  c_conv: cover property (@(posedge hclk) disable iff (!hresetn) $fell(busy));
  c_fast: cover property (@(posedge hclk) disable iff (!hresetn) $fell(busy) && mode_reg == scs_pkg::MODE_FAST);
  c_lowpwr: cover property (@(posedge hclk) disable iff (!hresetn) $rose(analog_power_on));
endmodule // scs_sequencer

// ### verif/scs_host_model.sv
// host-side model: turns a one-cycle fire request into a convert_start_n low pulse
// assumes the bench raises fire for one hclk cycle per wanted conversion
`timescale 1ns/1ps
module scs_host_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic fire,
  output logic      convert_start_n
);
  logic [2:0] low_cnt_reg;
  logic [2:0] low_cnt_next;
  // falling start edge
  // pulse held 4 cycles so the 2-flop synchroniser always sees it
  always_comb begin
    low_cnt_next = (low_cnt_reg != 3'h0) ? low_cnt_reg - 3'h1 : 3'h0;
    if (fire) begin
      low_cnt_next = 3'h4;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_reg <= 3'h0;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end
  assign convert_start_n = (low_cnt_reg == 3'h0);
endmodule // scs_host_model

// ### verif/sar_conversion_sequencer_test.sv
// self-checking bench for scs_sequencer: ahb-lite registers, start pin, coding
// assumes hreadyout answers without wait states but never relies on it
`timescale 1ns/1ps
module sar_conversion_sequencer_test;
  logic        hclk, hresetn, hsel, hwrite, hready, fire, over, under, sh, pwr, busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, cnv_n;
  logic [15:0] level, trial, result;
  int          failures = 0;
  int          cmp_count = 0;
  scs_host_model host_u (.hclk(hclk), .hresetn(hresetn), .fire(fire), .convert_start_n(cnv_n));
  scs_sequencer dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .convert_start_n(cnv_n), .analog_level(level),
    .analog_over(over), .analog_under(under), .busy(busy), .sample_hold(sh),
    .analog_power_on(pwr), .trial_code(trial), .result_code(result));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) chk("hreadyout", 32'h1, 32'h0);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, exp, q & m);
  endtask
  task automatic wait_busy(input logic v, output int n);
    n = 0;
    while (busy !== v && n < 1000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 1000) chk("busy_wait", {31'h0, v}, {31'h0, busy});
  endtask
  task automatic fire_start;
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
  endtask
  task automatic conv(output int len);
    int n;
    fire_start();
    wait_busy(1'b1, n);
    chk("sample_hold", 32'h1, {31'h0, sh});
    chk("trial_msb", 32'h8000, {16'h0, trial});
    wait_busy(1'b0, len);
    @(posedge hclk);
  endtask
  task automatic t_reset;
    rd_chk("ctrl_reset", scs_pkg::OFS_CTRL, scs_pkg::CTRL_RESET, 32'hFFFFFFFF);
    rd_chk("count_reset", scs_pkg::OFS_SAMPLE, 32'h0, 32'hFFFFFFFF);
    rd_chk("unmapped", 8'h10, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
  endtask
  task automatic t_fast;
    int len;
    wr(scs_pkg::OFS_CTRL, 32'h5);
    level <= 16'h1234;
    conv(len);
    chk("fast_len", 32'h1, {31'h0, len >= 80 && len <= 82});
    chk("result_port", 32'h1234, {16'h0, result});
    // discard first fast result after long gap
    rd_chk("stale_first", scs_pkg::OFS_STATUS, 32'h2, 32'h3);
    conv(len);
    rd_chk("stale_second", scs_pkg::OFS_STATUS, 32'h0, 32'h3);
    rd_chk("result_reg", scs_pkg::OFS_RESULT, 32'h1234, 32'hFFFF);
    $display("test fast done");
  endtask
  task automatic t_coding;
    logic [15:0] lv [6] = '{16'h8000, 16'h8000, 16'h0, 16'h0, 16'h5, 16'hFFF0};
    logic [1:0]  ou [6] = '{2'h0, 2'h0, 2'h2, 2'h2, 2'h1, 2'h1};
    logic [15:0] ex [6] = '{16'h8000, 16'h0000, 16'hFFFF, 16'h7FFF, 16'h0000, 16'h8000};
    int len;
    for (int i = 0; i < 6; i++) begin
      wr(scs_pkg::OFS_CTRL, (i % 2 == 0) ? 32'h4 : 32'h0);
      level <= lv[i];
      over <= ou[i][1];
      under <= ou[i][0];
      conv(len);
      chk("coded_result", {16'h0, ex[i]}, {16'h0, result});
    end
    chk("normal_len", 32'h1, {31'h0, len >= 96 && len <= 98});
    over <= 1'b0;
    under <= 1'b0;
    $display("test coding done");
  endtask
  task automatic t_ignore;
    int n;
    wr(scs_pkg::OFS_CTRL, 32'h4);
    level <= 16'hA5A5;
    fire_start();
    wait_busy(1'b1, n);
    repeat (10) @(posedge hclk);
    fire_start();
    wr(scs_pkg::OFS_CTRL, 32'hC);
    wait_busy(1'b0, n);
    repeat (20) @(posedge hclk);
    chk("busy_after", 32'h0, {31'h0, busy});
    chk("result_kept", 32'hA5A5, {16'h0, result});
    fire_start();
    repeat (20) @(posedge hclk);
    chk("pd_refused", 32'h0, {31'h0, busy});
    rd_chk("count", scs_pkg::OFS_SAMPLE, 32'h9, 32'hFFFFFFFF);
    $display("test ignore done");
  endtask
  task automatic t_lowpwr;
    int len;
    wr(scs_pkg::OFS_CTRL, 32'h6);
    repeat (10) @(posedge hclk);
    chk("power_idle", 32'h0, {31'h0, pwr});
    rd_chk("pwrsave", scs_pkg::OFS_STATUS, 32'h4, 32'h4);
    level <= 16'h00FF;
    conv(len);
    chk("lp_len", 32'h1, {31'h0, len >= 100 && len <= 102});
    chk("lp_result", 32'h00FF, {16'h0, result});
    wr(scs_pkg::OFS_CTRL, 32'h7);
    repeat (10) @(posedge hclk);
    chk("fast_wins", 32'h1, {31'h0, pwr});
    $display("test lowpwr done");
  endtask
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, fire, over, under} = 5'h0;
    hready = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    level = 16'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_fast();
    t_coding();
    t_ignore();
    t_lowpwr();
    end_of_test();
  end
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule // sar_conversion_sequencer_test
